// ===== design/pta_defines.vh
// Purpose: constants for the ptp adjust and message config block
// Assumes: Avalon-MM word addressing, byte address = 4 * index
// Notes: indexes are the printed 16-bit offsets
`ifndef PTA_DEFINES_VH
`define PTA_DEFINES_VH
`define PTA_IDX_RATE_HI 12'h50C
`define PTA_IDX_RATE_LO 12'h50E
`define PTA_IDX_DUR_HI 12'h510
`define PTA_IDX_DUR_LO 12'h512
`define PTA_IDX_MSG_CFG 12'h514
`define PTA_IDX_STATUS 12'h518
`define PTA_ADDR_W 14
`define PTA_DUR_RESET 16'h0000
`define PTA_RATE_RESET 16'h0000
`define PTA_MSG_CFG_RESET 8'h39
`define PTA_MSG_CFG_MASK 16'h00FF
`define PTA_BIT_STEP 0
`define PTA_BIT_ROLE 1
`define PTA_BIT_TCSEL 2
`define PTA_BIT_DET_V6 3
`define PTA_BIT_DET_V4 4
`define PTA_BIT_DET_ETH 5
`define PTA_BIT_PTP_EN 6
`define PTA_BIT_GPTP 7
`define PTA_BIT_RATE_DIR 15
`define PTA_BIT_TEMP_EN 14
`define PTA_RATE_HI_MASK 16'hBFFF
`define PTA_CLK_HZ 25000000
`endif

// ===== design/pta_dur_counter.v
// Purpose: down-counter timing a temporary rate adjustment
// Assumes: one mclk cycle per 25 MHz tick
// Notes: a zero duration ends at once
`timescale 1ns/1ps
module pta_dur_counter #(
   parameter WIDTH = 32
) (
   mclk,
   reset,
   start,
   stop,
   duration,
   active,
   remaining
);
   input wire mclk;
   input wire reset;
   input wire start;
   input wire stop;
   input wire [WIDTH-1:0] duration;
   output reg active;
   output reg [WIDTH-1:0] remaining;

   always @(posedge mclk) begin
      if (reset) begin
         active <= 1'b0;
         remaining <= {WIDTH{1'b0}};
      end else if (stop) begin
         active <= 1'b0;
         remaining <= {WIDTH{1'b0}};
      end else if (start) begin
         remaining <= duration;
         active <= (duration != {WIDTH{1'b0}});
      end else if (active) begin
         remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
         if (remaining == {{(WIDTH-1){1'b0}}, 1'b1}) begin
            active <= 1'b0;
         end
      end
   end
endmodule // pta_dur_counter

// ===== design/pta_mode_decode.v
// Purpose: turns the message config bits into effective mode levels
// Assumes: config bits stable from registers on the same clock
// Notes: purely combinational; the top registers the outputs
`timescale 1ns/1ps
`include "pta_defines.vh"
module pta_mode_decode (
   cfg,
   ptpOn,
   gptpOn,
   detEth,
   detV4,
   detV6,
   peerToPeer,
   hostMaster,
   oneStep
);
   input wire [7:0] cfg;
   output wire ptpOn;
   output wire gptpOn;
   output wire detEth;
   output wire detV4;
   output wire detV6;
   output wire peerToPeer;
   output wire hostMaster;
   output wire oneStep;

   assign ptpOn = cfg[`PTA_BIT_PTP_EN];
   assign gptpOn = cfg[`PTA_BIT_GPTP] & cfg[`PTA_BIT_PTP_EN];
   // detection only matters with ptp mode on
   assign detEth = ptpOn & cfg[`PTA_BIT_DET_ETH];
   assign detV4 = ptpOn & cfg[`PTA_BIT_DET_V4];
   assign detV6 = ptpOn & cfg[`PTA_BIT_DET_V6];
   assign peerToPeer = cfg[`PTA_BIT_TCSEL];
   assign hostMaster = cfg[`PTA_BIT_ROLE];
   assign oneStep = cfg[`PTA_BIT_STEP];
endmodule // pta_mode_decode

// ===== design/pta_ptp_config.v
// Purpose: ptp temporary adjustment timing and message mode registers
// Assumes: Avalon-MM slave, word addressed bytes, 16-bit data in low bits
// Notes: every access answers one cycle after it is seen
`timescale 1ns/1ps
`include "pta_defines.vh"
module pta_ptp_config #(
   parameter DUR_W = 32
) (
   mclk,
   reset,
   avsAddress,
   avsRead,
   avsWrite,
   avsWritedata,
   avsByteenable,
   avsReaddata,
   avsWaitrequest,
   ptpClockRun,
   ptpClassify,
   ptpHeaderRewrite,
   ptpTimestampTag,
   allToHost,
   detectEth,
   detectIpv4,
   detectIpv6,
   peerToPeer,
   hostMaster,
   oneStep,
   tempAdjActive,
   rateStep,
   rateAdd,
   rateSub
);
   input wire mclk;
   input wire reset;
   input wire [`PTA_ADDR_W-1:0] avsAddress;
   input wire avsRead;
   input wire avsWrite;
   input wire [31:0] avsWritedata;
   input wire [3:0] avsByteenable;
   output reg [31:0] avsReaddata;
   output reg avsWaitrequest;
   output reg ptpClockRun;
   output reg ptpClassify;
   output reg ptpHeaderRewrite;
   output reg ptpTimestampTag;
   output reg allToHost;
   output reg detectEth;
   output reg detectIpv4;
   output reg detectIpv6;
   output reg peerToPeer;
   output reg hostMaster;
   output reg oneStep;
   output reg tempAdjActive;
   output reg [29:0] rateStep;
   output reg rateAdd;
   output reg rateSub;

   reg [15:0] durHi_reg;
   reg [15:0] durLo_reg;
   reg [7:0] msgCfg_reg;
   reg [15:0] rateHi_reg;
   reg [15:0] rateLo_reg;
   // bus answer states
   localparam [1:0] BUS_IDLE = 2'h0;
   localparam [1:0] BUS_ANSWER = 2'h1;
   reg [1:0] busState_reg;
   reg [1:0] busState_next;
   reg [15:0] rdata_next;
   reg [15:0] wmerged;
   reg [15:0] rdCur;
   wire [11:0] idx;
   wire access;
   wire wrStrobe;
   wire rateHiWr;
   wire tempStart;
   wire tempStop;
   wire cntActive;
   wire mPtpOn;
   wire mGptpOn;
   wire mDetEth;
   wire mDetV4;
   wire mDetV6;
   wire mP2p;
   wire mMaster;
   wire mOneStep;
   // next values of the registered outputs
   reg ptpClockRun_next;
   reg ptpClassify_next;
   reg ptpHeaderRewrite_next;
   reg ptpTimestampTag_next;
   reg allToHost_next;
   reg detectEth_next;
   reg detectIpv4_next;
   reg detectIpv6_next;
   reg peerToPeer_next;
   reg hostMaster_next;
   reg oneStep_next;
   reg tempAdjActive_next;
   reg [29:0] rateStep_next;
   reg rateAdd_next;
   reg rateSub_next;

   // byte address to 16-bit register index; low two bits ignored
   assign idx = avsAddress[`PTA_ADDR_W-1:2];
   assign access = (avsRead | avsWrite) && (busState_reg == BUS_IDLE);
   assign wrStrobe = avsWrite && (busState_reg == BUS_IDLE);

   // merge byte enables into a 16-bit write value
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] wd;
      input [1:0] be;
      begin
         merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
      end
   endfunction

   // a rate high write with its upper lane enabled
   function rateHiWrite;
      input strobe;
      input [11:0] index;
      input laneHi;
      begin
         rateHiWrite = strobe && (index == `PTA_IDX_RATE_HI) && laneHi;
      end
   endfunction

   // one answer per request; a held request is not taken twice
   always @* begin
      busState_next = busState_reg;
      case (busState_reg)
         BUS_IDLE: begin
            if (access) begin
               busState_next = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            busState_next = BUS_IDLE;
         end
         default: begin
            busState_next = BUS_IDLE;
         end
      endcase
   end

   // read mux; the temp enable is a trigger and reads 0
   always @* begin
      case (idx)
         `PTA_IDX_RATE_HI: rdCur = rateHi_reg;
         `PTA_IDX_RATE_LO: rdCur = rateLo_reg;
         `PTA_IDX_DUR_HI: rdCur = durHi_reg;
         `PTA_IDX_DUR_LO: rdCur = durLo_reg;
         `PTA_IDX_MSG_CFG: rdCur = {8'h00, msgCfg_reg};
         `PTA_IDX_STATUS: rdCur = {15'h0000, cntActive};
         default: rdCur = 16'h0000;
      endcase
      wmerged = merge16(rdCur, avsWritedata[15:0], avsByteenable[1:0]);
      rdata_next = rdCur;
   end

   // waitrequest high except in the answer cycle; one cycle latency
   always @(posedge mclk) begin
      if (reset) begin
         busState_reg <= BUS_IDLE;
         avsWaitrequest <= 1'b1;
         avsReaddata <= 32'h00000000;
      end else begin
         busState_reg <= busState_next;
         avsWaitrequest <= ~access;
         if (access && avsRead) begin
            avsReaddata <= {16'h0000, rdata_next};
         end
      end
   end

   // writing the temp enable bit starts or stops the adjustment
   assign rateHiWr = rateHiWrite(wrStrobe, idx, avsByteenable[1]);
   assign tempStart = rateHiWr && avsWritedata[`PTA_BIT_TEMP_EN];
   // leaving ptp mode cancels a running adjustment
   assign tempStop = (rateHiWr && !avsWritedata[`PTA_BIT_TEMP_EN]) || !msgCfg_reg[`PTA_BIT_PTP_EN];

   // config writes land at the edge that takes the request
   always @(posedge mclk) begin
      if (reset) begin
         durHi_reg <= `PTA_DUR_RESET;
         durLo_reg <= `PTA_DUR_RESET;
         rateHi_reg <= `PTA_RATE_RESET;
         rateLo_reg <= `PTA_RATE_RESET;
         msgCfg_reg <= `PTA_MSG_CFG_RESET;
      end else if (wrStrobe) begin
         case (idx)
            `PTA_IDX_DUR_HI: durHi_reg <= wmerged;
            `PTA_IDX_DUR_LO: durLo_reg <= wmerged;
            `PTA_IDX_RATE_HI: rateHi_reg <= wmerged & `PTA_RATE_HI_MASK;
            `PTA_IDX_RATE_LO: rateLo_reg <= wmerged;
            `PTA_IDX_MSG_CFG: msgCfg_reg <= wmerged[7:0];
            default: begin
            end
         endcase
      end
   end

   pta_dur_counter #(
      .WIDTH(DUR_W)
   ) uCount (
      .mclk(mclk),
      .reset(reset),
      .start(tempStart),
      .stop(tempStop),
      .duration({durHi_reg, durLo_reg}),
      .active(cntActive),
      .remaining()
   );

   pta_mode_decode uMode (
      .cfg(msgCfg_reg),
      .ptpOn(mPtpOn),
      .gptpOn(mGptpOn),
      .detEth(mDetEth),
      .detV4(mDetV4),
      .detV6(mDetV6),
      .peerToPeer(mP2p),
      .hostMaster(mMaster),
      .oneStep(mOneStep)
   );

   // mode levels decoded here, registered below so every output is a flop
   always @* begin
      ptpClockRun_next = mPtpOn;
      ptpClassify_next = mPtpOn;
      ptpHeaderRewrite_next = mPtpOn & ~mGptpOn;
      ptpTimestampTag_next = mPtpOn;
      allToHost_next = mGptpOn;
      detectEth_next = mDetEth;
      detectIpv4_next = mDetV4;
      detectIpv6_next = mDetV6;
      peerToPeer_next = mP2p;
      hostMaster_next = mMaster;
      oneStep_next = mOneStep;
      tempAdjActive_next = cntActive;
      rateStep_next = {rateHi_reg[13:0], rateLo_reg};
      // step pulses only during the adjustment window
      rateAdd_next = cntActive & rateHi_reg[`PTA_BIT_RATE_DIR];
      rateSub_next = cntActive & ~rateHi_reg[`PTA_BIT_RATE_DIR];
   end

   // registered mode levels for the forwarding datapath
   always @(posedge mclk) begin
      if (reset) begin
         ptpClockRun <= 1'b0;
         ptpClassify <= 1'b0;
         ptpHeaderRewrite <= 1'b0;
         ptpTimestampTag <= 1'b0;
         allToHost <= 1'b0;
         detectEth <= 1'b0;
         detectIpv4 <= 1'b0;
         detectIpv6 <= 1'b0;
         peerToPeer <= 1'b0;
         hostMaster <= 1'b0;
         oneStep <= 1'b1;
         tempAdjActive <= 1'b0;
         rateStep <= 30'h0000000;
         rateAdd <= 1'b0;
         rateSub <= 1'b0;
      end else begin
         ptpClockRun <= ptpClockRun_next;
         ptpClassify <= ptpClassify_next;
         ptpHeaderRewrite <= ptpHeaderRewrite_next;
         ptpTimestampTag <= ptpTimestampTag_next;
         allToHost <= allToHost_next;
         detectEth <= detectEth_next;
         detectIpv4 <= detectIpv4_next;
         detectIpv6 <= detectIpv6_next;
         peerToPeer <= peerToPeer_next;
         hostMaster <= hostMaster_next;
         oneStep <= oneStep_next;
         tempAdjActive <= tempAdjActive_next;
         rateStep <= rateStep_next;
         rateAdd <= rateAdd_next;
         rateSub <= rateSub_next;
      end
   end
endmodule // pta_ptp_config

// ===== verification/pta_host_model.sv
// Purpose: host side Avalon-MM master driving the config block
// Assumes: answer comes when waitrequest is sampled low
// Notes: no wait bound here, the bench watchdog ends a hang
`timescale 1ns/1ps
module pta_host_model (
   input wire mclk,
   input wire [31:0] avsReaddata,
   input wire avsWaitrequest,
   output reg [13:0] avsAddress = 14'h0000,
   output reg avsRead = 1'b0,
   output reg avsWrite = 1'b0,
   output reg [31:0] avsWritedata = 32'h00000000,
   output reg [3:0] avsByteenable = 4'hF
);
   // an idle edge first, so a strobe is never dropped and raised at one edge
   task automatic wr(input [13:0] a, input [15:0] d);
      wrb(a, d, 4'hF);
   endtask
   // one write with chosen byte lanes
   task automatic wrb(input [13:0] a, input [15:0] d, input [3:0] be);
      @(posedge mclk);
      avsAddress <= a;
      avsWritedata <= {16'h0000, d};
      avsByteenable <= be;
      avsWrite <= 1'b1;
      @(posedge mclk);
      while (avsWaitrequest) @(posedge mclk);
      avsWrite <= 1'b0;
   endtask
   task automatic rd(input [13:0] a, output [15:0] d);
      @(posedge mclk);
      avsAddress <= a;
      avsRead <= 1'b1;
      @(posedge mclk);
      while (avsWaitrequest) @(posedge mclk);
      d = avsReaddata[15:0];
      avsRead <= 1'b0;
   endtask
endmodule // pta_host_model

// ===== verification/pta_ptp_config_asserts.sv
// Purpose: port level checks of the config block
// Assumes: single mclk domain, sync reset
// Notes: mode outputs are registered levels
`timescale 1ns/1ps
module pta_ptp_config_asserts #(
   parameter DUR_W = 32
) (
   input logic mclk,
   input logic reset,
   input logic avsRead,
   input logic avsWrite,
   input logic [31:0] avsReaddata,
   input logic avsWaitrequest,
   input logic ptpClockRun,
   input logic ptpClassify,
   input logic ptpHeaderRewrite,
   input logic ptpTimestampTag,
   input logic allToHost,
   input logic oneStep,
   input logic tempAdjActive,
   input logic rateAdd,
   input logic rateSub
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence sReqSeen;
      $rose(avsRead || avsWrite);
   endsequence
   sequence sAnswer;
      !avsWaitrequest ##1 avsWaitrequest;
   endsequence
   a_ans_next: assert property (sReqSeen |=> sAnswer) else $error("answer not one cycle");
   a_wait_cause: assert property (!avsWaitrequest |-> $past(avsRead || avsWrite)) else $error("stray answer");
   a_rd_upper: assert property (avsReaddata[31:16] == 16'h0000) else $error("upper data set");
   a_gptp_gate: assert property (allToHost |-> ptpClockRun) else $error("gptp without ptp");
   a_hdr_keep: assert property (allToHost |-> !ptpHeaderRewrite) else $error("header rewrite in gptp");
   a_cls_run: assert property (ptpClassify == ptpClockRun) else $error("classify mismatch");
   a_tag_run: assert property (ptpTimestampTag == ptpClockRun) else $error("tail tag mismatch");
   a_dir_excl: assert property (rateAdd || rateSub |-> tempAdjActive && !(rateAdd && rateSub))
      else $error("rate direction bad");
   a_rst_vals: assert property ($fell(reset) |-> oneStep && !ptpClockRun) else $error("reset levels");
endmodule // pta_ptp_config_asserts
bind pta_ptp_config pta_ptp_config_asserts #(.DUR_W(DUR_W)) asrt_i (.mclk, .reset, .avsRead, .avsWrite,
   .avsReaddata, .avsWaitrequest, .ptpClockRun, .ptpClassify, .ptpHeaderRewrite, .ptpTimestampTag,
   .allToHost, .oneStep, .tempAdjActive, .rateAdd, .rateSub);

// ===== verification/pta_ptp_config_tb.sv
// Purpose: self-checking bench of the config block
// Assumes: host model speaks the register bus
// Notes: byte address is four times the word index
`timescale 1ns/1ps
module pta_ptp_config_tb;
   reg mclk = 1'b0;
   reg reset = 1'b1;
   wire [13:0] avsAddress;
   wire [31:0] avsWritedata, avsReaddata;
   wire [3:0] avsByteenable;
   wire [29:0] rateStep;
   wire avsRead, avsWrite, avsWaitrequest, ptpClockRun, ptpClassify, ptpHeaderRewrite, ptpTimestampTag;
   wire allToHost, detectEth, detectIpv4, detectIpv6, peerToPeer, hostMaster, oneStep, tempAdjActive;
   wire rateAdd, rateSub;
   integer n_errors = 0, n_compared = 0, i, cnt, n, dir;
   logic [15:0] v, hi, lo;
   always #20 mclk = ~mclk;
   pta_ptp_config pta_ptp_config_i (.mclk, .reset, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
      .avsByteenable, .avsReaddata, .avsWaitrequest, .ptpClockRun, .ptpClassify, .ptpHeaderRewrite,
      .ptpTimestampTag, .allToHost, .detectEth, .detectIpv4, .detectIpv6, .peerToPeer, .hostMaster,
      .oneStep, .tempAdjActive, .rateStep, .rateAdd, .rateSub);
   pta_host_model pta_host_model_i (.mclk, .avsReaddata, .avsWaitrequest, .avsAddress, .avsRead,
      .avsWrite, .avsWritedata, .avsByteenable);
   task automatic chk_val(input string nm, input [31:0] e, input [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_rd(input [13:0] a, input [15:0] e);
      logic [15:0] g;
      pta_host_model_i.rd(a, g);
      chk_val("readback", e, g);
   endtask
   function automatic [10:0] expMode(input [15:0] c);
      expMode = {c[6], c[6], c[6] & ~c[7], c[6], c[6] & c[7], c[6] & c[5], c[6] & c[4], c[6] & c[3], c[2:0]};
   endfunction
   wire [10:0] modeSeen = {ptpClockRun, ptpClassify, ptpHeaderRewrite, ptpTimestampTag, allToHost,
      detectEth, detectIpv4, detectIpv6, peerToPeer, hostMaster, oneStep};
   task automatic tally_and_finish;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'hDBE2));
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      chk_rd(14'h1440, 16'h0000);
      chk_rd(14'h1448, 16'h0000);
      chk_rd(14'h1450, 16'h0039);
      chk_val("mode", expMode(16'h0039), modeSeen);
      $display("test reset done");
      // single bits with ptp on, gptp without ptp, then random with reserved bits
      for (i = 0; i < 12; i++) begin
         v = (i < 8) ? (16'h0040 | (16'h0001 << i)) : (i == 8) ? 16'hFFBF : $urandom;
         pta_host_model_i.wr(14'h1450, v);
         repeat (2) @(posedge mclk);
         #1;
         chk_val("mode", expMode(v), modeSeen);
         chk_rd(14'h1450, v & 16'h00FF);
      end
      $display("test modes done");
      n = 3 + $urandom % 6;
      dir = $urandom % 2;
      lo = $urandom;
      hi = $urandom & 16'h3FFF;
      pta_host_model_i.wr(14'h1440, 16'h0000);
      pta_host_model_i.wr(14'h1448, n[15:0]);
      chk_rd(14'h1448, n[15:0]);
      pta_host_model_i.wr(14'h1450, 16'h0040);
      pta_host_model_i.wr(14'h1438, lo);
      pta_host_model_i.wr(14'h1430, {dir[0], 1'b1, hi[13:0]});
      cnt = 0;
      // first active level stands right after the write's answer edge
      #1;
      repeat (40) begin
         if (tempAdjActive === 1'b1) begin
            cnt++;
            chk_val("rate", {dir[0], !dir[0], hi[13:0], lo}, {rateAdd, rateSub, rateStep});
         end
         @(posedge mclk);
         #1;
      end
      chk_val("adjust cycles", n, cnt);
      // direction reads back, the temp enable trigger does not
      chk_rd(14'h1430, {dir[0], 1'b0, hi[13:0]});
      $display("test adjust done");
      // long run cut short by clearing the enable
      pta_host_model_i.wr(14'h1448, 16'h00C8);
      pta_host_model_i.wr(14'h1430, hi | 16'h4000);
      repeat (5) @(posedge mclk);
      #1;
      chk_val("active", 1, tempAdjActive);
      chk_rd(14'h1460, 16'h0001);
      pta_host_model_i.wr(14'h1430, hi);
      repeat (3) @(posedge mclk);
      #1;
      chk_val("stopped", 0, tempAdjActive);
      chk_rd(14'h1460, 16'h0000);
      pta_host_model_i.wrb(14'h1448, 16'hAB34, 4'h2);
      chk_rd(14'h1448, 16'hABC8);
      pta_host_model_i.wr(14'h0000, 16'hFFFF);
      chk_rd(14'h0000, 16'h0000);
      $display("test stop and unmapped done");
      // reset again in mid-run: registers go back to their reset values
      reset <= 1'b1;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      chk_rd(14'h1448, 16'h0000);
      chk_rd(14'h1430, 16'h0000);
      chk_rd(14'h1450, 16'h0039);
      chk_val("mode", expMode(16'h0039), modeSeen);
      $display("test second reset done");
      tally_and_finish;
   end
endmodule // pta_ptp_config_tb
